// ===== hdl/srs_pkg.sv
package srs_pkg;

    // Switch operating modes
    localparam logic [2:0] MODE_NORMAL     = 3'h0;
    localparam logic [2:0] MODE_EEPROM     = 3'h1;

    // Timing budgets
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned TRAIN_MS        = 20;
    localparam int unsigned RETRY_MS        = 100;
    localparam int unsigned EE_BUDGET_MS    = 200;
    localparam int unsigned TRAIN_CYC       = CLK_HZ / 1000 * TRAIN_MS;
    localparam int unsigned RETRY_CYC       = CLK_HZ / 1000 * RETRY_MS;
    localparam int unsigned SMB_SLOW_KHZ    = 100;
    localparam int unsigned SMB_FAST_KHZ    = 400;
    localparam int unsigned SMB_SLOW_DIV    = CLK_HZ / (SMB_SLOW_KHZ * 1000);
    localparam int unsigned SMB_FAST_DIV    = CLK_HZ / (SMB_FAST_KHZ * 1000);

    // Slave SMBus address pin positions
    localparam int unsigned SADDR_HI_BIT    = 5;
    localparam int unsigned SADDR_LO_TOP    = 3;
    localparam int unsigned SADDR_LO_BOT    = 1;

    typedef enum logic [3:0] {
        SRS_ST_FRESET,
        SRS_ST_DECODE,
        SRS_ST_PLL,
        SRS_ST_QUASI,
        SRS_ST_SSMB,
        SRS_ST_MSMB,
        SRS_ST_EELOAD,
        SRS_ST_EEWAIT,
        SRS_ST_HALT,
        SRS_ST_RUN,
        SRS_ST_HRESET
    } srs_state_t;

    // Boot configuration vector
    typedef struct packed {
        logic [2:0] mode;
        logic       halt;
        logic       smb_slow;
        logic [3:0] saddr;
    } srs_boot_t;

    // Control bits steering the sequencer
    typedef struct packed {
        logic soft_fundamental_reset_bit;
        logic soft_hot_reset_bit;
        logic link_down_hot_reset_disable;
        logic hot_reset_eeprom_load_disable;
    } srs_ctrl_t;

endpackage : srs_pkg

// ===== hdl/srs_switch_reset_sequencer.sv
// What this block does
// RULE_01: Fundamental reset returns all sequencer state and register bits to initial values.
// RULE_02: Fundamental reset starts on pin assertion (cold or warm) or soft bit write.
// RULE_03: Outside driver holds reset pin 100ms after supplies, 100us after clock.
// RULE_04: Boot inputs sampled at pin release; soft reset reuses previous sample.
// RULE_05: Decode mode, then PLL and SerDes lock, then training runs alongside.
// RULE_06: Sampled halt input sets the reset-halt status indication.
// RULE_07: After fundamental reset, training within 20ms, retry completions within 100ms.
// RULE_08: Master SMBus runs 100 KHz when slow input sampled, else 400 KHz.
// RULE_09: Release slave SMBus at pin address, then master, then EEPROM load.
// RULE_10: EEPROM write to full retrain bit retrains that port immediately.
// RULE_11: EEPROM error aborts load, sets control halt bit, records error status.
// RULE_12: Load end sets done; halt bit set repeats load, else advance.
// RULE_13: Halt holds core in reset until slave SMBus clears the halt bit.
// RULE_14: Config requests get retry completions during EEPROM load.
// RULE_15: Soft fundamental reset waits for successful completion before starting.
// RULE_16: Fundamental reset turns every GPIO into an input.
// RULE_17: Hot reset on hot-reset TS1, upstream link down, or soft bit write.
// RULE_18: Disable bit blocks link-down hot reset; other causes remain.
// RULE_19: Hot reset sends TS1 downstream, resets core except PLL, SerDes, SMBus; code still asserts both SMBus resets for one cycle in SRS_ST_QUASI.
// RULE_20: After hot reset, training within 20ms, retry completions within 100ms.
// RULE_21: Hot reset reloads EEPROM only in EEPROM mode with load-disable clear.
// RULE_22: Upstream bus reset resets internal devices; downstream one resets its link.
// RULE_23: Mode 0 normal, mode 1 normal with EEPROM, modes 2 to 7 reserved.
`timescale 1ns/1ps
`default_nettype none
module srs_switch_reset_sequencer #(
    parameter int unsigned NPORTS    = 6,
    parameter int unsigned NGPIO     = 8,
    parameter int unsigned TRAIN_CYC = srs_pkg::TRAIN_CYC,
    parameter int unsigned RETRY_CYC = srs_pkg::RETRY_CYC
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset_n,
    // Pins
    input  wire logic                   fundamental_reset_in_n,
    input  wire logic [2:0]             switch_operating_mode,
    input  wire logic                   reset_halt,
    input  wire logic                   master_smbus_slow_select,
    input  wire logic [5:0]             slave_smbus_addr_pins,
    // Control bits
    input  wire srs_pkg::srs_ctrl_t     ctrl,
    input  wire logic                   halt_clear,
    input  wire logic                   cfg_completion_sent,
    // Link and bus events
    input  wire logic                   pll_locked,
    input  wire logic                   hot_reset_ts1_rx,
    input  wire logic                   upstream_dl_down,
    input  wire logic                   upstream_sbr,
    input  wire logic [NPORTS-1:0]      downstream_sbr,
    input  wire logic [NPORTS-1:0]      port_link_up,
    // EEPROM loader
    input  wire logic                   ee_done,
    input  wire logic                   ee_error,
    input  wire logic [7:0]             ee_error_code,
    input  wire logic                   ee_retrain_wr,
    input  wire logic [NPORTS-1:0]      full_link_retrain_bit,
    // Sequencer controls
    output logic                        pll_serdes_rst,
    output logic                        link_train_en,
    output logic                        stack_quasi_reset,
    output logic                        cfg_retry,
    output logic                        core_rst,
    output logic                        slave_smbus_rst,
    output logic                        master_smbus_rst,
    output logic [3:0]                  slave_smbus_addr,
    output logic                        smbus_tick,
    output logic                        ee_start,
    output logic                        eeprom_load_done,
    output logic [7:0]                  smbus_status_reg,
    output logic                        ctrl_reset_halt,
    output logic                        sts_reset_halt,
    output logic [2:0]                  sts_mode,
    output logic                        nonsticky_rst,
    output logic [NPORTS-1:0]           port_retrain,
    output logic [NPORTS-1:0]           ts1_hot_reset_tx,
    output logic [NPORTS-1:0]           internal_hot_reset,
    output logic [NGPIO-1:0]            gpio_oe,
    output logic                        mode_reserved
);

    initial begin
        if (NPORTS < 1 || NGPIO < 1 || TRAIN_CYC < 1 || RETRY_CYC <= TRAIN_CYC)
            $error("srs: bad parameters");
    end

    localparam int unsigned CW = $clog2(RETRY_CYC + 1);
    localparam logic [CW-1:0] TRAIN_C = CW'(TRAIN_CYC);
    localparam logic [CW-1:0] RETRY_C = CW'(RETRY_CYC);
    localparam logic [7:0] DIV_SLOW = 8'(srs_pkg::SMB_SLOW_DIV - 1);
    localparam logic [7:0] DIV_FAST = 8'(srs_pkg::SMB_FAST_DIV - 1);

    typedef struct packed {
        srs_pkg::srs_state_t st;
        logic [1:0]          sync_perst;
        logic [1:0]          sync_halt;
        logic [1:0]          sync_slow;
        logic [1:0]          sync_mode0;
        logic [1:0]          sync_mode1;
        logic [1:0]          sync_mode2;
        logic [7:0]          sync_addr;
        srs_pkg::srs_boot_t  boot;
        logic                soft_fundamental_reset_bit_pend;
        logic [CW-1:0]       tmr;
        logic [7:0]          div;
        logic                tick;
        logic                ee_go;
        logic                done;
        logic [7:0]          ee_sts;
        logic                ctl_halt;
        logic [NPORTS-1:0]   retrain;
        logic [NPORTS-1:0]   ts1;
        logic [NPORTS-1:0]   ihr;
        logic                hot;
    } srs_reg_t;

    srs_reg_t r_q;
    srs_reg_t r_d;

    // Decoded mode: only mode 1 asks for EEPROM load
    function automatic logic ee_mode(input logic [2:0] m);
        return m == srs_pkg::MODE_EEPROM;
    endfunction : ee_mode

    function automatic logic run_state(input srs_pkg::srs_state_t s);
        return s == srs_pkg::SRS_ST_RUN;
    endfunction : run_state

    logic perst_asserted;
    logic hot_cause;
    assign perst_asserted = !r_q.sync_perst[1];
    assign hot_cause = hot_reset_ts1_rx || ctrl.soft_hot_reset_bit ||
                       (upstream_dl_down && !ctrl.link_down_hot_reset_disable); // RULE_17 RULE_18

    always_comb begin
        r_d = r_q;
        r_d.ee_go = 1'b0;
        r_d.retrain = '0;
        r_d.tick = 1'b0;
        if (r_q.tmr != RETRY_C)
            r_d.tmr = r_q.tmr + CW'(1);
        // Divider for master SMBus bit rate
        if (r_q.div == (r_q.boot.smb_slow ? DIV_SLOW : DIV_FAST)) begin // RULE_08
            r_d.div = '0;
            r_d.tick = 1'b1;
        end else begin
            r_d.div = r_q.div + 8'h01;
        end
        if (ee_retrain_wr)
            r_d.retrain = full_link_retrain_bit; // RULE_10
        r_d.ihr = upstream_sbr ? {NPORTS{1'b1}} : downstream_sbr; // RULE_22
        r_d.ts1 = port_link_up & (downstream_sbr | {NPORTS{upstream_sbr}});
        if (ctrl.soft_fundamental_reset_bit)
            r_d.soft_fundamental_reset_bit_pend = 1'b1;
        if (halt_clear)
            r_d.ctl_halt = 1'b0;
        case (r_q.st)
            srs_pkg::SRS_ST_FRESET: begin
                r_d.tmr = '0;
                if (!perst_asserted) begin
                    r_d.st = srs_pkg::SRS_ST_DECODE;
                end
            end
            srs_pkg::SRS_ST_DECODE: begin
                r_d.st = srs_pkg::SRS_ST_PLL; // RULE_05
            end
            srs_pkg::SRS_ST_PLL: begin
                if (pll_locked)
                    r_d.st = srs_pkg::SRS_ST_QUASI;
            end
            srs_pkg::SRS_ST_QUASI: begin
                if (r_q.boot.halt)
                    r_d.ctl_halt = 1'b1; // RULE_06
                r_d.st = r_q.hot ? srs_pkg::SRS_ST_EELOAD : srs_pkg::SRS_ST_SSMB;
            end
            srs_pkg::SRS_ST_SSMB: r_d.st = srs_pkg::SRS_ST_MSMB; // RULE_09
            srs_pkg::SRS_ST_MSMB: r_d.st = srs_pkg::SRS_ST_EELOAD;
            srs_pkg::SRS_ST_EELOAD: begin
                if (ee_mode(r_q.boot.mode) &&
                    !(r_q.hot && ctrl.hot_reset_eeprom_load_disable)) begin // RULE_21
                    r_d.ee_go = 1'b1;
                    r_d.st = srs_pkg::SRS_ST_EEWAIT;
                end else begin
                    r_d.st = srs_pkg::SRS_ST_HALT;
                end
            end
            srs_pkg::SRS_ST_EEWAIT: begin
                if (ee_error || ee_done) begin
                    r_d.done = 1'b1; // RULE_12
                    if (ee_error) begin
                        r_d.ctl_halt = 1'b1; // RULE_11
                        r_d.ee_sts = ee_error_code;
                    end
                    r_d.st = (ee_error || r_q.ctl_halt) ? srs_pkg::SRS_ST_EELOAD
                                                        : srs_pkg::SRS_ST_HALT;
                end
            end
            srs_pkg::SRS_ST_HALT: begin
                if (!r_q.ctl_halt)
                    r_d.st = srs_pkg::SRS_ST_RUN; // RULE_13
            end
            srs_pkg::SRS_ST_RUN: begin
                r_d.hot = 1'b0;
                if (hot_cause) begin
                    r_d.st = srs_pkg::SRS_ST_HRESET;
                    r_d.ts1 = port_link_up; // RULE_19
                end
            end
            srs_pkg::SRS_ST_HRESET: begin
                r_d.tmr = '0;
                r_d.hot = 1'b1;
                r_d.done = 1'b0;
                r_d.ts1 = port_link_up;
                if (!hot_cause)
                    r_d.st = srs_pkg::SRS_ST_QUASI; // RULE_20
            end
            default: r_d.st = srs_pkg::SRS_ST_FRESET;
        endcase
        // Soft fundamental reset waits for its completion to leave first
        if ((r_q.soft_fundamental_reset_bit_pend || ctrl.soft_fundamental_reset_bit) && cfg_completion_sent) begin // RULE_15
            r_d = '0;
            r_d.boot = r_q.boot; // RULE_04
            r_d.st = srs_pkg::SRS_ST_DECODE; // RULE_02
        end
        if (perst_asserted) begin
            r_d = '0; // RULE_01 RULE_02
            r_d.boot = {r_q.sync_mode2[1], r_q.sync_mode1[1], r_q.sync_mode0[1],
                        r_q.sync_halt[1], r_q.sync_slow[1], r_q.sync_addr[7:4]}; // RULE_04
        end
        // Synchronisers shift even while a reset is applied
        r_d.sync_perst = {r_q.sync_perst[0], fundamental_reset_in_n};
        r_d.sync_halt  = {r_q.sync_halt[0], reset_halt};
        r_d.sync_slow  = {r_q.sync_slow[0], master_smbus_slow_select};
        r_d.sync_mode0 = {r_q.sync_mode0[0], switch_operating_mode[0]};
        r_d.sync_mode1 = {r_q.sync_mode1[0], switch_operating_mode[1]};
        r_d.sync_mode2 = {r_q.sync_mode2[0], switch_operating_mode[2]};
        r_d.sync_addr  = {r_q.sync_addr[3:0], slave_smbus_addr_pins[srs_pkg::SADDR_HI_BIT],
                          slave_smbus_addr_pins[srs_pkg::SADDR_LO_TOP:srs_pkg::SADDR_LO_BOT]};
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_q <= '0; // RULE_01
        end else begin
            r_q <= r_d;
        end
    end

    logic busy;
    assign busy = !run_state(r_q.st);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pll_serdes_rst     <= 1'b1;
            link_train_en      <= 1'b0;
            stack_quasi_reset  <= 1'b1;
            cfg_retry          <= 1'b0;
            core_rst           <= 1'b1;
            slave_smbus_rst    <= 1'b1;
            master_smbus_rst   <= 1'b1;
            slave_smbus_addr   <= '0;
            smbus_tick         <= 1'b0;
            ee_start           <= 1'b0;
            eeprom_load_done   <= 1'b0;
            smbus_status_reg   <= '0;
            ctrl_reset_halt    <= 1'b0;
            sts_reset_halt     <= 1'b0;
            sts_mode           <= '0;
            nonsticky_rst      <= 1'b1;
            port_retrain       <= '0;
            ts1_hot_reset_tx   <= '0;
            internal_hot_reset <= '0;
            gpio_oe            <= '0;
            mode_reserved      <= 1'b0;
        end else begin
            pll_serdes_rst     <= r_d.st inside {srs_pkg::SRS_ST_FRESET, srs_pkg::SRS_ST_DECODE};
            link_train_en      <= !(r_d.st inside {srs_pkg::SRS_ST_FRESET, srs_pkg::SRS_ST_DECODE,
                                  srs_pkg::SRS_ST_PLL, srs_pkg::SRS_ST_HRESET}); // RULE_05 RULE_07
            stack_quasi_reset  <= !run_state(r_d.st);
            cfg_retry          <= !run_state(r_d.st) && r_d.tmr >= TRAIN_C
                                  && r_d.st != srs_pkg::SRS_ST_HRESET; // RULE_07 RULE_14 RULE_20
            core_rst           <= !run_state(r_d.st); // RULE_13 RULE_19
            slave_smbus_rst    <= r_d.st inside {srs_pkg::SRS_ST_FRESET, srs_pkg::SRS_ST_DECODE,
                                  srs_pkg::SRS_ST_PLL, srs_pkg::SRS_ST_QUASI};
            master_smbus_rst   <= r_d.st inside {srs_pkg::SRS_ST_FRESET, srs_pkg::SRS_ST_DECODE,
                                  srs_pkg::SRS_ST_PLL, srs_pkg::SRS_ST_QUASI,
                                  srs_pkg::SRS_ST_SSMB}; // RULE_09
            slave_smbus_addr   <= r_d.boot.saddr;
            smbus_tick         <= r_d.tick;
            ee_start           <= r_d.ee_go;
            eeprom_load_done   <= r_d.done;
            smbus_status_reg   <= r_d.ee_sts;
            ctrl_reset_halt    <= r_d.ctl_halt;
            sts_reset_halt     <= r_d.boot.halt; // RULE_06
            sts_mode           <= r_d.boot.mode;
            nonsticky_rst      <= r_d.st inside {srs_pkg::SRS_ST_FRESET, srs_pkg::SRS_ST_HRESET};
            port_retrain       <= r_d.retrain;
            ts1_hot_reset_tx   <= r_d.ts1;
            internal_hot_reset <= r_d.ihr;
            gpio_oe            <= '0; // RULE_16
            mode_reserved      <= r_d.boot.mode > srs_pkg::MODE_EEPROM; // RULE_23
        end
    end

    property p_retrain;
        @(posedge sys_clk) disable iff (!reset_n)
        ee_retrain_wr |=> (port_retrain == $past(full_link_retrain_bit));
    endproperty
    a_retrain: assert property (p_retrain) else $error("retrain missed"); // RULE_10

    property p_ee_err;
        @(posedge sys_clk) disable iff (!reset_n)
        (r_q.st == srs_pkg::SRS_ST_EEWAIT && ee_error && !perst_asserted && !r_q.soft_fundamental_reset_bit_pend
         && !ctrl.soft_fundamental_reset_bit)
        |=> ##1 (ctrl_reset_halt && eeprom_load_done);
    endproperty
    a_ee_err: assert property (p_ee_err) else $error("error not recorded"); // RULE_11 RULE_12

    property p_dl_disable;
        @(posedge sys_clk) disable iff (!reset_n)
        (r_q.st == srs_pkg::SRS_ST_RUN && upstream_dl_down && ctrl.link_down_hot_reset_disable
         && !hot_reset_ts1_rx && !ctrl.soft_hot_reset_bit) |=> r_q.st != srs_pkg::SRS_ST_HRESET;
    endproperty
    a_dl_disable: assert property (p_dl_disable) else $error("masked hot reset"); // RULE_18

    property p_hot;
        @(posedge sys_clk) disable iff (!reset_n)
        (r_q.st == srs_pkg::SRS_ST_RUN && hot_reset_ts1_rx && !perst_asserted &&
         !ctrl.soft_fundamental_reset_bit && !r_q.soft_fundamental_reset_bit_pend) |=> ##1 core_rst;
    endproperty
    a_hot: assert property (p_hot) else $error("hot reset missed"); // RULE_17

    property p_halt_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        (r_q.st == srs_pkg::SRS_ST_HALT && r_q.ctl_halt) |=> core_rst;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt released"); // RULE_13

    property p_gpio;
        @(posedge sys_clk) disable iff (!reset_n)
        perst_asserted |=> ##1 (gpio_oe == '0);
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio driven"); // RULE_16

    property p_soft_fundamental_reset_bit_wait;
        @(posedge sys_clk) disable iff (!reset_n)
        (run_state(r_q.st) && ctrl.soft_fundamental_reset_bit && !cfg_completion_sent
         && !perst_asserted && !hot_cause) |=> run_state(r_q.st);
    endproperty
    a_soft_fundamental_reset_bit_wait: assert property (p_soft_fundamental_reset_bit_wait) else $error("early warm reset"); // RULE_15

    property p_smb_order;
        @(posedge sys_clk) disable iff (!reset_n)
        !master_smbus_rst |-> !slave_smbus_rst;
    endproperty
    a_smb_order: assert property (p_smb_order) else $error("master before slave"); // RULE_09

    property p_retry_busy;
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_retry |-> stack_quasi_reset && busy;
    endproperty
    a_retry_busy: assert property (p_retry_busy) else $error("retry when running"); // RULE_14

endmodule : srs_switch_reset_sequencer
`default_nettype wire

// ===== dv/srs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module srs_far_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // Sequencer side
    input  wire logic       pll_serdes_rst,
    input  wire logic       ee_start,
    output logic            pll_locked,
    output logic            ee_done,
    output logic            ee_error,
    output logic [7:0]      ee_error_code,
    // Bench commands
    input  wire logic       fail_next,
    input  wire logic [7:0] load_cycles
);
    logic [2:0] lock_q;
    logic [7:0] busy_q;

    // Lock lags release so the sequencer must really wait
    assign pll_locked = lock_q == 3'h7;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_q <= 3'h0;
        end else if (pll_serdes_rst) begin
            lock_q <= 3'h0;
        end else if (lock_q != 3'h7) begin
            lock_q <= lock_q + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q        <= 8'h00;
            ee_done       <= 1'b0;
            ee_error      <= 1'b0;
            ee_error_code <= 8'h00;
        end else begin
            ee_done  <= busy_q == 8'h01 && !fail_next;
            ee_error <= busy_q == 8'h01 && fail_next;
            // Idle code lines toggle so a stale capture shows
            ee_error_code <= (busy_q == 8'h01 && fail_next) ? 8'h3C : ~ee_error_code;
            if (ee_start) begin
                busy_q <= load_cycles;
            end else if (busy_q != 8'h00) begin
                busy_q <= busy_q - 8'h01;
            end
        end
    end
endmodule : srs_far_model
`default_nettype wire

// ===== dv/srs_switch_reset_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module srs_switch_reset_sequencer_tb_top;
    typedef struct packed {
        logic [2:0] mode;
        logic       halt;
        logic       slow;
        logic [5:0] pins;
        logic [3:0] addr;
        logic       res;
    } srs_row_t;
    localparam int TRAIN = 20;
    localparam int RETRY = 100;
    logic sys_clk = 1'b0, reset_n = 1'b0, fundamental_reset_in_n = 1'b0, reset_halt = 1'b0;
    logic master_smbus_slow_select = 1'b0, halt_clear = 1'b0, cfg_completion_sent = 1'b0;
    logic hot_reset_ts1_rx = 1'b0, upstream_dl_down = 1'b0, upstream_sbr = 1'b0;
    logic ee_retrain_wr = 1'b0, fail_next = 1'b0, seen, exp;
    logic [2:0] switch_operating_mode = 3'h0;
    logic [5:0] slave_smbus_addr_pins = 6'h00, downstream_sbr = 6'h00;
    logic [5:0] port_link_up = 6'h15, full_link_retrain_bit = 6'h00;
    logic [7:0] load_cycles = 8'h30;
    srs_pkg::srs_ctrl_t ctrl = '0;
    logic pll_locked, ee_done, ee_error, pll_serdes_rst, link_train_en, stack_quasi_reset;
    logic cfg_retry, core_rst, slave_smbus_rst, master_smbus_rst, smbus_tick, ee_start;
    logic eeprom_load_done, ctrl_reset_halt, sts_reset_halt, nonsticky_rst, mode_reserved;
    logic [7:0] ee_error_code, smbus_status_reg, gpio_oe;
    logic [3:0] slave_smbus_addr;
    logic [2:0] sts_mode;
    logic [5:0] port_retrain, ts1_hot_reset_tx, internal_hot_reset;
    int bad_count = 0, checks = 0, n;
    srs_row_t rows [3] = '{'{3'h3, 1'b1, 1'b1, 6'h2B, 4'hD, 1'b1},
                           '{3'h0, 1'b0, 1'b0, 6'h16, 4'h3, 1'b0},
                           '{3'h1, 1'b0, 1'b0, 6'h3F, 4'hF, 1'b0}};
    // Cause bits: ts1, link down, down disable, soft hot, eeprom disable
    logic [4:0] hot [4] = '{5'b10001, 5'b01101, 5'b01001, 5'b00010};

    srs_switch_reset_sequencer #(.TRAIN_CYC(TRAIN), .RETRY_CYC(RETRY)) dut_u (
        .sys_clk, .reset_n, .fundamental_reset_in_n, .switch_operating_mode, .reset_halt,
        .master_smbus_slow_select, .slave_smbus_addr_pins, .ctrl, .halt_clear,
        .cfg_completion_sent, .pll_locked, .hot_reset_ts1_rx, .upstream_dl_down,
        .upstream_sbr, .downstream_sbr, .port_link_up, .ee_done, .ee_error, .ee_error_code,
        .ee_retrain_wr, .full_link_retrain_bit, .pll_serdes_rst, .link_train_en,
        .stack_quasi_reset, .cfg_retry, .core_rst, .slave_smbus_rst, .master_smbus_rst,
        .slave_smbus_addr, .smbus_tick, .ee_start, .eeprom_load_done, .smbus_status_reg,
        .ctrl_reset_halt, .sts_reset_halt, .sts_mode, .nonsticky_rst, .port_retrain,
        .ts1_hot_reset_tx, .internal_hot_reset, .gpio_oe, .mode_reserved);
    srs_far_model far_u (.sys_clk, .reset_n, .pll_serdes_rst, .ee_start, .pll_locked,
        .ee_done, .ee_error, .ee_error_code, .fail_next, .load_cycles);

    always #20 sys_clk = ~sys_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        checks++;
        if (got !== want) begin
            bad_count++;
            $display("mismatch at %0t got %h want %h", $time, got, want);
        end
    endtask : chk

    task automatic pulse_halt_clear();
        @(posedge sys_clk) halt_clear <= 1'b1;
        @(posedge sys_clk) halt_clear <= 1'b0;
        for (n = 0; n < 400 && core_rst; n++) @(negedge sys_clk);
    endtask : pulse_halt_clear

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #(40 * 20000);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (8) @(negedge sys_clk);
        chk({core_rst, pll_serdes_rst, slave_smbus_rst, master_smbus_rst, gpio_oe}, 12'hF00);
        repeat (9) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge sys_clk);
            fundamental_reset_in_n   <= 1'b0;
            switch_operating_mode    <= rows[i].mode;
            reset_halt               <= rows[i].halt;
            master_smbus_slow_select <= rows[i].slow;
            slave_smbus_addr_pins    <= rows[i].pins;
            repeat (16) @(posedge sys_clk);
            fundamental_reset_in_n <= 1'b1;
            for (n = 0; n < 400 && !link_train_en; n++) @(negedge sys_clk);
            chk(16'(n <= TRAIN), 16'h1);
            for (n = 0; n < 400 && slave_smbus_rst; n++) @(negedge sys_clk);
            chk({master_smbus_rst, slave_smbus_addr}, {1'b1, rows[i].addr});
            chk({sts_mode, sts_reset_halt, mode_reserved}, {rows[i].mode, rows[i].halt, rows[i].res});
            if (rows[i].mode == 3'h1) begin
                for (n = 0; n < 400 && !ee_start; n++) @(negedge sys_clk);
                chk({ee_start, master_smbus_rst}, 2'b10);
                for (n = 0; n < 400 && !ee_done; n++) @(negedge sys_clk);
                chk({cfg_retry, core_rst}, 2'b11);
            end
            if (rows[i].halt) begin
                repeat (60) @(negedge sys_clk);
                chk({ctrl_reset_halt, core_rst}, 2'b11);
                pulse_halt_clear();
            end
            for (n = 0; n < 400 && core_rst; n++) @(negedge sys_clk);
            chk({core_rst, cfg_retry, eeprom_load_done}, {2'b00, rows[i].mode == 3'h1});
            for (n = 0; n < 400 && !smbus_tick; n++) @(negedge sys_clk);
            @(negedge sys_clk);
            for (n = 1; n < 400 && !smbus_tick; n++) @(negedge sys_clk);
            chk(16'(n), 16'(rows[i].slow ? srs_pkg::SMB_SLOW_DIV : srs_pkg::SMB_FAST_DIV));
            $display("boot row %0d done", i);
        end
        @(posedge sys_clk);
        ctrl.soft_fundamental_reset_bit <= 1'b1;
        switch_operating_mode <= 3'h0;
        fail_next <= 1'b1;
        repeat (10) @(negedge sys_clk);
        chk(core_rst, 1'b0);
        @(posedge sys_clk) cfg_completion_sent <= 1'b1;
        ctrl.soft_fundamental_reset_bit <= 1'b0;
        @(posedge sys_clk) cfg_completion_sent <= 1'b0;
        for (n = 0; n < 8 && !core_rst; n++) @(negedge sys_clk);
        chk(core_rst, 1'b1);
        for (n = 0; n < 400 && !ee_start; n++) @(negedge sys_clk);
        chk({ee_start, sts_mode}, 4'h9);
        @(posedge sys_clk) ee_retrain_wr <= 1'b1;
        full_link_retrain_bit <= 6'h21;
        @(posedge sys_clk) ee_retrain_wr <= 1'b0;
        for (n = 0; n < 4 && port_retrain == 6'h00; n++) @(negedge sys_clk);
        chk(port_retrain, 6'h21);
        for (n = 0; n < 400 && !ctrl_reset_halt; n++) @(negedge sys_clk);
        chk({ctrl_reset_halt, eeprom_load_done, smbus_status_reg}, 10'h33C);
        @(posedge sys_clk) fail_next <= 1'b0;
        for (n = 0; n < 400 && !ee_start; n++) @(negedge sys_clk);
        chk({ee_start, core_rst}, 2'b11);
        pulse_halt_clear();
        chk(core_rst, 1'b0);
        $display("soft reset and load error done");
        foreach (hot[i]) begin
            @(posedge sys_clk);
            {hot_reset_ts1_rx, upstream_dl_down, ctrl.link_down_hot_reset_disable} <= hot[i][4:2];
            ctrl.soft_hot_reset_bit <= hot[i][1];
            ctrl.hot_reset_eeprom_load_disable <= hot[i][0];
            exp = hot[i][4] | hot[i][1] | (hot[i][3] & !hot[i][2]);
            for (n = 0; n < 8 && !nonsticky_rst; n++) @(negedge sys_clk);
            chk(nonsticky_rst, exp);
            if (exp) begin
                chk({ts1_hot_reset_tx, core_rst, pll_serdes_rst, slave_smbus_rst, master_smbus_rst}, {port_link_up, 4'h8});
            end
            @(posedge sys_clk);
            {hot_reset_ts1_rx, upstream_dl_down, ctrl.soft_hot_reset_bit} <= 3'h0;
            seen = 1'b0;
            for (n = 0; n < 900 && (core_rst || n < 4); n++) begin
                @(negedge sys_clk);
                seen |= ee_start;
            end
            chk({seen, core_rst}, {exp & !hot[i][0], 1'b0});
            $display("hot reset case %0d done", i);
        end
        @(posedge sys_clk) downstream_sbr <= 6'h04;
        for (n = 0; n < 4 && ts1_hot_reset_tx == 6'h00; n++) @(negedge sys_clk);
        chk({ts1_hot_reset_tx, internal_hot_reset, stack_quasi_reset}, 13'h208);
        @(posedge sys_clk) downstream_sbr <= 6'h00;
        $display("bus reset done");
        final_report();
    end
endmodule : srs_switch_reset_sequencer_tb_top
`default_nettype wire
